// *** src_core.sv ***
`timescale 1ns/10ps
module src_core
    import src_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h5A // Arbitrary bus address
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Crystal
    input  wire logic i_crystal_in,
    output logic      o_crystal_out,
    // Power sense
    input  wire logic i_main_power_ok,
    output logic      o_on_backup,
    // Two-wire link
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe,
    // Shared open-drain pin
    output logic      o_shared_open_drain_output,
    output logic      o_shared_open_drain_output_oe,
    // Time view
    output src_time_t o_time,
    output logic      o_sec_tick
);

    typedef struct packed {
        logic                               scl1;
        logic                               scl2;
        logic                               scl3;
        logic                               sda1;
        logic                               sda2;
        logic                               sda3;
        logic                               pw1;
        logic                               pw2;
        logic                               backup;
        src_i2c_st_t                        st;
        logic [7:0]                         sh;
        logic [2:0]                         cnt;
        logic                               done;
        logic                               rw;
        logic                               nack;
        logic [7:0]                         ptr;
        logic                               sda_oe;
        logic                               out_oe;
        logic                               wr;
        logic [2:0]                         widx;
        logic [7:0]                         wdata;
        logic [NUM_CTL_BYTES-1:0][7:0]      ctl;
    } src_core_st_t;

    src_core_st_t q, n;
    src_time_t    cal_time;
    logic         cal_sec;
    logic         ft_wave;
    logic         sr;
    logic         sf;
    logic         start;
    logic         stop;
    logic         load_rd;
    logic         alarm_hit;
    logic         irq;
    logic [7:0]   rd;
    logic [3:0]   cidx;
    logic [3:0]   ridx;

    // Timekeeping runs on regardless of the supply in use
    src_cal u_cal (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_crystal_in  (i_crystal_in),
        .o_crystal_out (o_crystal_out),
        .i_wr          (q.wr),
        .i_widx        (q.widx),
        .i_wdata       (q.wdata),
        .o_time        (cal_time),
        .o_sec_tick    (cal_sec),
        .o_ft_wave     (ft_wave)
    );

    // Line events from synchronised levels only
    always_comb begin
        sr = q.scl2 & ~q.scl3;
        sf = ~q.scl2 & q.scl3;
        start = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
        stop = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
        cidx = 4'(q.ptr - CTL_BASE);
        alarm_hit = cal_sec
            && ({1'b0, q.ctl[CI_ALM_MON][6:0]} == cal_time.month)
            && (q.ctl[CI_ALM_DATE] == cal_time.date)
            && (q.ctl[CI_ALM_HOUR] == cal_time.hour)
            && (q.ctl[CI_ALM_MIN] == cal_time.min)
            && (q.ctl[CI_ALM_SEC] == cal_time.sec);
        irq = q.ctl[CI_FLAGS][FLAG_ALM_BIT] & q.ctl[CI_ALM_MON][ALM_IRQ_BIT];
    end

    // Serial slave, register bytes, alarm and pin sharing
    always_comb begin
        n = q;
        n.wr = 1'b0;
        load_rd = 1'b0;
        rd = 8'h00;
        ridx = 4'h0;
        n.scl1 = i_scl;
        n.scl2 = q.scl1;
        n.scl3 = q.scl2;
        n.sda1 = i_sda;
        n.sda2 = q.sda1;
        n.sda3 = q.sda2;
        n.pw1 = i_main_power_ok;
        n.pw2 = q.pw1;
        n.backup = ~q.pw2;
        // Bits are taken on the rising clock edge
        if (sr) begin
            case (q.st)
                S_ADDR, S_PTR, S_WDATA: begin
                    n.sh = {q.sh[6:0], q.sda2};
                    n.cnt = q.cnt + 3'h1;
                    n.done = (q.cnt == 3'h7);
                end
                S_RDATA: begin
                    n.cnt = q.cnt + 3'h1;
                    n.done = (q.cnt == 3'h7);
                end
                S_RACK: n.nack = q.sda2;
                default: ;
            endcase
        end
        // Data line only changes while the clock is low
        if (sf) begin
            case (q.st)
                S_ADDR: if (q.done) begin
                    n.done = 1'b0;
                    if (q.sh[7:1] == DEV_ADDR) begin
                        n.rw = q.sh[0];
                        n.st = S_AACK;
                        n.sda_oe = 1'b1;
                    end else begin
                        n.st = S_IDLE;
                    end
                end
                S_AACK: begin
                    n.sda_oe = 1'b0;
                    n.cnt = 3'h0;
                    if (q.rw) begin
                        load_rd = 1'b1;
                    end else begin
                        n.st = S_PTR;
                    end
                end
                S_PTR: if (q.done) begin
                    n.done = 1'b0;
                    n.ptr = (q.sh > LAST_ADDR) ? 8'h00 : q.sh;
                    n.st = S_PACK;
                    n.sda_oe = 1'b1;
                end
                S_PACK, S_WACK: begin
                    n.sda_oe = 1'b0;
                    n.cnt = 3'h0;
                    n.st = S_WDATA;
                end
                S_WDATA: if (q.done) begin
                    n.done = 1'b0;
                    if (q.ptr < CTL_BASE) begin
                        n.wr = 1'b1;
                        n.widx = q.ptr[2:0];
                        n.wdata = q.sh;
                    end else begin
                        n.ctl[cidx] = q.sh;
                    end
                    n.ptr = nxt_ptr(q.ptr);
                    n.st = S_WACK;
                    n.sda_oe = 1'b1;
                end
                S_RDATA: if (q.done) begin
                    n.done = 1'b0;
                    n.sda_oe = 1'b0;
                    n.ptr = nxt_ptr(q.ptr);
                    n.st = S_RACK;
                end else begin
                    n.sh = {q.sh[6:0], 1'b0};
                    n.sda_oe = ~q.sh[6];
                end
                S_RACK: begin
                    n.cnt = 3'h0;
                    if (q.nack) begin
                        n.st = S_IDLE;
                    end else begin
                        load_rd = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Read clears the alarm flag; a hit below still wins
        if (load_rd) begin
            ridx = 4'(q.ptr - CTL_BASE);
            if (q.ptr < CTL_BASE) begin
                rd = time_byte(cal_time, q.ptr[2:0]);
            end else begin
                rd = q.ctl[ridx];
            end
            if (q.ptr == A_FLAGS) begin
                n.ctl[CI_FLAGS][FLAG_ALM_BIT] = 1'b0;
            end
            n.sh = rd;
            n.sda_oe = ~rd[7];
            n.st = S_RDATA;
        end
        if (start) begin
            n.st = S_ADDR;
            n.cnt = 3'h0;
            n.done = 1'b0;
            n.sda_oe = 1'b0;
        end
        if (stop) begin
            n.st = S_IDLE;
            n.sda_oe = 1'b0;
        end
        // On backup the link is deselected, the clock is not
        if (q.backup) begin
            n.st = S_IDLE;
            n.sda_oe = 1'b0;
        end
        // Alarm compare ignores the supply state
        if (alarm_hit) begin
            n.ctl[CI_FLAGS][FLAG_ALM_BIT] = 1'b1;
        end
        // Pin priority: interrupt, test tone, square wave, level
        if (irq) begin
            n.out_oe = 1'b1;
        end else if (q.ctl[CI_CTRL][CTRL_FT_BIT]) begin
            n.out_oe = ~ft_wave;
        end else if (q.ctl[CI_SQW][SQW_EN_BIT]) begin
            n.out_oe = (cal_time.hund < SQW_HALF);
        end else begin
            n.out_oe = ~q.ctl[CI_CTRL][CTRL_OUT_BIT];
        end
    end

    // Lines idle high after reset so no false start is seen
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
            q.scl1 <= 1'b1;
            q.scl2 <= 1'b1;
            q.scl3 <= 1'b1;
            q.sda1 <= 1'b1;
            q.sda2 <= 1'b1;
            q.sda3 <= 1'b1;
            q.pw1 <= 1'b1;
            q.pw2 <= 1'b1;
            q.st <= S_IDLE;
        end else begin
            q <= n;
        end
    end

    assign o_sda = 1'b0;
    assign o_sda_oe = q.sda_oe;
    assign o_on_backup = q.backup;
    assign o_shared_open_drain_output = 1'b0;
    assign o_shared_open_drain_output_oe = q.out_oe;
    assign o_time = cal_time;
    assign o_sec_tick = cal_sec;

    chk_ptr_write: assert property (@(posedge i_clk) disable iff (i_srst)
        (q.st == S_WDATA && n.st == S_WACK)
        |=> (q.ptr == nxt_ptr($past(q.ptr))))
        else $error("pointer did not step after write");
    chk_ptr_read: assert property (@(posedge i_clk) disable iff (i_srst)
        (q.st == S_RDATA && n.st == S_RACK)
        |=> (q.ptr == nxt_ptr($past(q.ptr))))
        else $error("pointer did not step after read");
    chk_ctl_store: assert property (@(posedge i_clk) disable iff (i_srst)
        (q.st == S_WDATA && n.st == S_WACK && q.ptr == CTL_BASE)
        |=> (q.ctl[CI_CTRL] == $past(q.sh)))
        else $error("control byte not stored");
    chk_backup_desel: assert property (@(posedge i_clk) disable iff (i_srst)
        q.backup |=> (!o_sda_oe && q.st == S_IDLE))
        else $error("link driven while on backup");
    chk_alarm_flag: assert property (@(posedge i_clk) disable iff (i_srst)
        alarm_hit |=> q.ctl[CI_FLAGS][FLAG_ALM_BIT])
        else $error("alarm hit did not set flag");
    chk_shared_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        irq |=> o_shared_open_drain_output_oe)
        else $error("interrupt not on shared pin");
    chk_ack_drive: assert property (@(posedge i_clk) disable iff (i_srst)
        (q.st == S_AACK || q.st == S_PACK || q.st == S_WACK) |-> o_sda_oe)
        else $error("acknowledge not driven");

endmodule

// *** src_pkg.sv ***
package src_pkg;

    // Byte locations
    localparam int unsigned NUM_TIME_BYTES = 8;
    localparam int unsigned NUM_CTL_BYTES  = 12;
    localparam logic [7:0]  CTL_BASE       = 8'h08;
    localparam logic [7:0]  LAST_ADDR      = 8'h13;
    localparam logic [7:0]  A_FLAGS        = 8'h0F;
    localparam int unsigned CI_CTRL        = 0;
    localparam int unsigned CI_ALM_MON     = 2;
    localparam int unsigned CI_ALM_DATE    = 3;
    localparam int unsigned CI_ALM_HOUR    = 4;
    localparam int unsigned CI_ALM_MIN     = 5;
    localparam int unsigned CI_ALM_SEC     = 6;
    localparam int unsigned CI_FLAGS       = 7;
    localparam int unsigned CI_SQW         = 11;

    // Field positions
    localparam int unsigned CTRL_OUT_BIT   = 7;
    localparam int unsigned CTRL_FT_BIT    = 6;
    localparam int unsigned ALM_IRQ_BIT    = 7;
    localparam int unsigned FLAG_ALM_BIT   = 6;
    localparam int unsigned SQW_EN_BIT     = 7;

    // Time base
    localparam int unsigned CRYSTAL_HZ     = 32768;
    localparam int unsigned HUND_PER_S     = 100;
    localparam int unsigned FT_DIV_BITS    = 6;
    localparam logic [7:0]  SQW_HALF       = 8'h50;

    typedef struct packed {
        logic [1:0] cent;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
        logic [7:0] hund;
    } src_time_t;

    localparam src_time_t TIME_RST = {2'h0, 8'h00, 8'h01, 8'h01, 8'h01,
                                      8'h00, 8'h00, 8'h00, 8'h00};

    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_ADDR  = 4'h1,
        S_AACK  = 4'h2,
        S_PTR   = 4'h3,
        S_PACK  = 4'h4,
        S_WDATA = 4'h5,
        S_WACK  = 4'h6,
        S_RDATA = 4'h7,
        S_RACK  = 4'h8
    } src_i2c_st_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {4'(v[7:4] + 4'h1), 4'h0};
        end
        return {v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction

    // Years 00 to 99 in BCD; 2100 is not special
    function automatic logic [7:0] days_in_month(input logic [7:0] m,
                                                 input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02:   return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    function automatic logic [7:0] time_byte(input src_time_t t,
                                             input logic [2:0] idx);
        case (idx)
            3'h0:    return t.hund;
            3'h1:    return t.sec;
            3'h2:    return t.min;
            3'h3:    return {t.cent, t.hour[5:0]};
            3'h4:    return t.day;
            3'h5:    return t.date;
            3'h6:    return t.month;
            default: return t.year;
        endcase
    endfunction

    function automatic logic [7:0] nxt_ptr(input logic [7:0] p);
        return (p >= LAST_ADDR) ? 8'h00 : 8'(p + 8'h01);
    endfunction

endpackage

// *** src_cal.sv ***
`timescale 1ns/10ps
module src_cal
    import src_pkg::*;
#(
    parameter int unsigned XTAL_HZ = CRYSTAL_HZ
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Crystal
    input  wire logic       i_crystal_in,
    output logic            o_crystal_out,
    // Byte load
    input  wire logic       i_wr,
    input  wire logic [2:0] i_widx,
    input  wire logic [7:0] i_wdata,
    // Time out
    output src_time_t       o_time,
    output logic            o_sec_tick,
    output logic            o_ft_wave
);

    initial begin
        if (XTAL_HZ <= HUND_PER_S || XTAL_HZ >= 65536) begin
            $error("src_cal: crystal rate out of range");
        end
    end

    localparam logic [16:0] XTAL = 17'(XTAL_HZ);
    localparam logic [16:0] STEP = 17'(HUND_PER_S);

    typedef struct packed {
        logic                   xs1;
        logic                   xs2;
        logic                   xprev;
        logic                   xo;
        logic [15:0]            acc;
        logic [FT_DIV_BITS-1:0] div;
        logic                   tick;
        logic                   sec_tick;
        src_time_t              t;
    } src_cal_st_t;

    src_cal_st_t q, n;
    logic        edge_x;
    logic [16:0] sum;
    logic        c;

    // Fractional divider: 100 per edge, wrap at crystal rate
    always_comb begin
        n = q;
        n.tick = 1'b0;
        n.sec_tick = 1'b0;
        n.xs1 = i_crystal_in;
        n.xs2 = q.xs1;
        n.xprev = q.xs2;
        n.xo = ~q.xs2;
        edge_x = q.xs2 & ~q.xprev;
        sum = 17'(q.acc) + STEP;
        c = 1'b0;
        if (edge_x) begin
            n.div = q.div + 1'b1;
            if (sum >= XTAL) begin
                n.acc = 16'(sum - XTAL);
                n.tick = 1'b1;
            end else begin
                n.acc = sum[15:0];
            end
        end
        // Carry chain; each unit steps only on the carry below
        if (q.tick) begin
            if (q.t.hund == 8'h99) begin
                n.t.hund = 8'h00;
                c = 1'b1;
                n.sec_tick = 1'b1;
            end else begin
                n.t.hund = bcd_inc(q.t.hund);
            end
            if (c) begin
                c = (q.t.sec == 8'h59);
                n.t.sec = c ? 8'h00 : bcd_inc(q.t.sec);
            end
            if (c) begin
                c = (q.t.min == 8'h59);
                n.t.min = c ? 8'h00 : bcd_inc(q.t.min);
            end
            if (c) begin
                c = (q.t.hour >= 8'h23);
                n.t.hour = c ? 8'h00 : bcd_inc(q.t.hour);
            end
            if (c) begin
                n.t.day = (q.t.day >= 8'h07) ? 8'h01 : bcd_inc(q.t.day);
                c = (q.t.date >= days_in_month(q.t.month, q.t.year));
                n.t.date = c ? 8'h01 : bcd_inc(q.t.date);
            end
            if (c) begin
                c = (q.t.month >= 8'h12);
                n.t.month = c ? 8'h01 : bcd_inc(q.t.month);
            end
            if (c) begin
                c = (q.t.year == 8'h99);
                n.t.year = c ? 8'h00 : bcd_inc(q.t.year);
            end
            if (c) begin
                n.t.cent = q.t.cent + 2'h1;
            end
        end
        // A load beats the tick for the byte written
        if (i_wr) begin
            case (i_widx)
                3'h0: n.t.hund = i_wdata;
                3'h1: n.t.sec = i_wdata;
                3'h2: n.t.min = i_wdata;
                3'h3: begin
                    n.t.cent = i_wdata[7:6];
                    n.t.hour = {2'h0, i_wdata[5:0]};
                end
                3'h4: n.t.day = i_wdata;
                3'h5: n.t.date = i_wdata;
                3'h6: n.t.month = i_wdata;
                default: n.t.year = i_wdata;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            q <= '0;
            q.t <= TIME_RST;
        end else begin
            q <= n;
        end
    end

    assign o_time = q.t;
    assign o_sec_tick = q.sec_tick;
    assign o_ft_wave = q.div[FT_DIV_BITS-1];
    assign o_crystal_out = q.xo;

    chk_hund_wrap: assert property (@(posedge i_clk) disable iff (i_srst)
        (q.tick && q.t.hund == 8'h99 && !i_wr)
        |=> (q.t.hund == 8'h00 && q.sec_tick))
        else $error("hundredths did not wrap with carry");
    chk_tick_edge: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(q.tick) |-> $past(edge_x))
        else $error("hundredth tick without crystal edge");
    chk_hour_range: assert property (@(posedge i_clk) disable iff (i_srst)
        q.t.hour <= 8'h23)
        else $error("hour outside 24-hour range");
    chk_date_limit: assert property (@(posedge i_clk) disable iff (i_srst)
        q.t.date <= days_in_month(q.t.month, q.t.year))
        else $error("date past end of month");
    chk_bcd_digits: assert property (@(posedge i_clk) disable iff (i_srst)
        q.t.sec[3:0] <= 4'h9 && q.t.min[3:0] <= 4'h9 && q.t.hund[3:0] <= 4'h9)
        else $error("time byte not BCD");

endmodule

// *** src_ctl_model.sv ***
`timescale 1ns/10ps
// Behavioural two-wire bus controller, about 397 kHz
module src_ctl_model (
    // Clock and wire
    input  wire logic i_clk,
    input  wire logic i_sda,
    // Driven lines
    output logic      o_scl,
    output logic      o_sda_oe
);
    // Bus idle, both lines released
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    // Quarter bit time, moves just after a clock edge
    task automatic q();
        repeat (63) @(posedge i_clk);
        #1;
    endtask

    // Also serves as repeated start from SCL low
    task automatic start();
        o_sda_oe = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b0;
        q();
    endtask

    task automatic stop();
        o_sda_oe = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_oe = 1'b0;
        q();
    endtask

    // SDA only moves while SCL is low
    task automatic bitx(input logic b, output logic r);
        o_sda_oe = ~b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask

    // MSB first, then sample the ack slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Ack asks for more, nack ends the read
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(~more, r);
    endtask
endmodule

// *** serial_rtc_calendar_core_bench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module serial_rtc_calendar_core_bench
    import src_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h5A; // Arbitrary bus address
    logic      i_clk, i_srst, i_crystal_in, i_main_power_ok, scl, m_oe;
    logic      o_sda, o_sda_oe, o_pin, o_pin_oe, o_xo, o_on_backup, o_tick;
    src_time_t o_time;
    int        error_cnt   = 0;
    int        checks_done = 0;
    int        cyc         = 0;
    int        seed        = 39156;
    // Pull-up wire: low if either side pulls
    wire       sda = ~((o_sda_oe & ~o_sda) | m_oe);

    // System clock and crystal, crystal at one sixteenth of the clock rate
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_crystal_in = 1'b0;
        forever #80 i_crystal_in = ~i_crystal_in;
    end

    src_core #(.DEV_ADDR(ADDR)) u_src_core (
        .i_clk(i_clk), .i_srst(i_srst), .i_crystal_in(i_crystal_in),
        .o_crystal_out(o_xo), .i_main_power_ok(i_main_power_ok),
        .o_on_backup(o_on_backup), .i_scl(scl), .i_sda(sda),
        .o_sda(o_sda), .o_sda_oe(o_sda_oe),
        .o_shared_open_drain_output(o_pin),
        .o_shared_open_drain_output_oe(o_pin_oe),
        .o_time(o_time), .o_sec_tick(o_tick));

    src_ctl_model u_src_ctl_model (
        .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, a full run needs about 105k cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 130000) begin
            error_cnt++;
            test_done();
        end
    end

    function automatic logic [7:0] bcd(input int n);
        return 8'(((n / 10) << 4) | (n % 10));
    endfunction
    function automatic int bin(input logic [7:0] v);
        return v[7:4] * 10 + v[3:0];
    endfunction
    // Plain divide-by-four leap rule, enough before 2100
    function automatic int last_day(input int m, input int y);
        if (m == 2) return (y % 4 == 0) ? 29 : 28;
        if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
        return 31;
    endfunction
    // Time one hundredth after 23:59:59.99
    function automatic src_time_t nxt(input src_time_t t);
        src_time_t r;
        int        m, y;
        r = t;
        m = bin(t.month);
        y = bin(t.year);
        {r.hour, r.min, r.sec, r.hund} = 32'h0;
        r.day = (t.day == 8'h07) ? 8'h01 : 8'(t.day + 8'h01);
        if (bin(t.date) == last_day(m, y)) begin
            r.date  = 8'h01;
            r.month = (m == 12) ? 8'h01 : bcd(m + 1);
            if (m == 12) r.year = bcd((y + 1) % 100);
            if (m == 12 && y == 99) r.cent = 2'(t.cent + 2'h1);
        end else begin
            r.date = bcd(bin(t.date) + 1);
        end
        return r;
    endfunction

    // One write transfer, every byte must be acked
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic a;
        u_src_ctl_model.start();
        u_src_ctl_model.wbyte({ADDR, 1'b0}, a);
        `CHK(a, 1'b1)
        u_src_ctl_model.wbyte(p, a);
        `CHK(a, 1'b1)
        foreach (d[i]) begin
            u_src_ctl_model.wbyte(d[i], a);
            `CHK(a, 1'b1)
        end
        u_src_ctl_model.stop();
    endtask

    // Pin released, alarm armed for 01-01 00:00:00, two bytes read back
    task automatic rd_ctl();
        logic [7:0] a, g;
        logic       k;
        a = 8'($random(seed));
        wr(8'h08, '{8'h80, a, 8'h81, 8'h01, 8'h00, 8'h00, 8'h00});
        u_src_ctl_model.start();
        u_src_ctl_model.wbyte({ADDR, 1'b0}, k);
        u_src_ctl_model.wbyte(8'h09, k);
        u_src_ctl_model.start();
        u_src_ctl_model.wbyte({ADDR, 1'b1}, k);
        `CHK(k, 1'b1)
        u_src_ctl_model.rbyte(1'b1, g);
        `CHK(g, a)
        u_src_ctl_model.rbyte(1'b0, g);
        `CHK(g, 8'h81)
        u_src_ctl_model.stop();
    endtask

    // Load a time, hundredths last so it cannot roll early
    task automatic roll(input src_time_t t, input logic bk);
        src_time_t e;
        e = nxt(t);
        wr(8'h01, '{t.sec, t.min, {t.cent, t.hour[5:0]}, t.day, t.date,
                    t.month, t.year});
        `CHK(o_time.date, t.date)
        `CHK(o_time.hour, t.hour)
        `CHK(o_time.cent, t.cent)
        // Two ticks to the carry, so it cannot pass before the wait
        wr(8'h00, '{8'h98});
        i_main_power_ok = ~bk;
        for (int i = 0; i < 12000 && o_tick !== 1'b1; i++) begin
            @(posedge i_clk);
            #1;
        end
        `CHK(o_tick, 1'b1)
        `CHK(o_on_backup, bk)
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(o_time, e)
        i_main_power_ok = 1'b1;
        repeat (8) @(posedge i_clk);
        #1;
    endtask

    // Main sequence
    initial begin
        src_time_t t;
        int        m, y;
        i_srst          = 1'b1;
        i_main_power_ok = 1'b1;
        repeat (16) @(posedge i_clk);
        #1 i_srst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        `CHK(o_time, TIME_RST)
        `CHK({o_pin_oe, o_pin}, 2'b10)
        rd_ctl();
        `CHK({o_pin_oe, o_pin}, 2'b00)
        // Century carry on backup; the alarm hits at the rollover
        roll('{2'h0, 8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59, 8'h99},
             1'b1);
        `CHK({o_pin_oe, o_pin}, 2'b10)
        // Random month end on main supply
        m = 1 + ($random(seed) & 32'hFFFF) % 12;
        y = ($random(seed) & 32'hFFFF) % 100;
        t = '{2'($random(seed)), bcd(y), bcd(m), bcd(last_day(m, y)),
              bcd(1 + ($random(seed) & 32'hFF) % 7), 8'h23, 8'h59, 8'h59,
              8'h99};
        roll(t, 1'b0);
        test_done();
    end
endmodule
